/* shared/scsc_pkg.sv */
// Shared constants and types for the structured cell sequence checker
`default_nettype none
package scsc_pkg;

  // Cell header layout: [7] CSI, [6:4] count, [3:1] CRC-3, [0] even parity
  localparam int unsigned HDR_W      = 8;
  localparam int unsigned SN_W       = 3;
  localparam int unsigned CRC_W      = 3;
  localparam int unsigned CNT_LSB    = 4;
  localparam int unsigned CRC_LSB    = 1;
  localparam int unsigned PAR_BIT    = 0;
  localparam logic [3:0]  CRC_POLY   = 4'hb;

  // Per-VC context store
  localparam int unsigned NUM_VC     = 256;
  localparam int unsigned VC_W       = 8;

  // Sequence arithmetic and dummy cell limit
  localparam logic [2:0]  SN_ONE     = 3'h1;
  localparam logic [2:0]  SN_TWO     = 3'h2;
  localparam logic [2:0]  SN_RST     = 3'h0;
  localparam logic [2:0]  MAX_LOST   = 3'h6;

  typedef enum logic [2:0] {
    ST_START,
    ST_OUT_OF_SYNC,
    ST_SYNC,
    ST_INVALID,
    ST_OUT_OF_SEQ
  } scsc_state_t;

endpackage : scsc_pkg
`default_nettype wire

/* core/scsc_sn_check.sv */
// Sequence number protection check: CRC-3 and even parity over the header
`timescale 1ns/1ns
`default_nettype none
module scsc_sn_check
  import scsc_pkg::*;
(
  // Header in
  input  wire logic [HDR_W-1:0] hdr_i,
  // Result
  output logic                  valid_o,
  output logic [SN_W-1:0]       count_o
);

  logic [CRC_W-1:0] crc_calc;
  logic [6:0]       rem;

  // Long division of the 4 protected bits shifted up by 3
  always_comb begin
    rem = {hdr_i[HDR_W-1:CNT_LSB], 3'h0};
    for (int i = 6; i >= CRC_W; i--) begin
      if (rem[i]) begin
        rem[i -: 4] = rem[i -: 4] ^ CRC_POLY;
      end
    end
    crc_calc = rem[CRC_W-1:0];
  end

  assign valid_o = (crc_calc == hdr_i[CRC_LSB +: CRC_W]) && !(^hdr_i);
  assign count_o = hdr_i[CNT_LSB +: SN_W];

endmodule // scsc_sn_check
`default_nettype wire

/* core/scsc_checker.sv */
// Per-VC structured-mode sequence number checking state machine
//
// Notes on behaviour
// - Out of sync, non-following valid cell is discarded; stay out of sync.
// - Out of sync, following cell is accepted and sync is entered.
// - Sync in-sequence cell accepted; only it permits signalling update.
// - Sync non-following valid cell accepted, sequence error raised, go out_of_seq.
// - Invalid or out_of_seq, cell after last good is misinsertion: discard, flag, sync.
// - Invalid state, good plus two is protection failure: accept, sync.
// - Invalid state, other valid cell discarded, go out of sync.
// - Out_of_seq, cell after last received: loss, dummies capped six, accept, sync.
// - Out_of_seq, good plus two is protection failure: accept, sync.
// - Out_of_seq, other valid cell discarded, go out of sync.
// - No dummies for late cells, none at first suspected single loss.
// - Dummies go after the out-of-order cell, before the current cell.
`timescale 1ns/1ns
`default_nettype none
module scsc_checker
  import scsc_pkg::*;
(
  // Clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             RST_I,
  // Cell from receive path
  input  wire logic             CELL_VALID_I,
  input  wire logic [VC_W-1:0]  CELL_VC_I,
  input  wire logic [HDR_W-1:0] CELL_HDR_I,
  // Verdict to reassembly_engine
  output logic                  READY_O,
  output logic [VC_W-1:0]       VC_O,
  output logic                  ACCEPT_O,
  output logic                  DISCARD_O,
  output logic                  DUMMY_O,
  output logic [SN_W-1:0]       DUMMY_CNT_O,
  output logic                  SIG_UPD_O,
  // Error events
  output logic                  SEQUENCE_ERROR_FLAG_O,
  output logic                  LOST_ERR_O,
  output logic                  MISINS_ERR_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Header check

  logic            sn_ok;
  logic [SN_W-1:0] rx_cnt;

  scsc_sn_check u_sn_check (
    .hdr_i   (CELL_HDR_I),
    .valid_o (sn_ok),
    .count_o (rx_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run flag: models the reset state, left one edge after release

  logic run_q;
  logic run_d;

  always_comb begin
    run_d = 1'b1;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-VC context: state, last good number, last received number

  scsc_state_t     st_mem_q   [NUM_VC];
  logic [SN_W-1:0] good_mem_q [NUM_VC];
  logic [SN_W-1:0] rx_mem_q   [NUM_VC];

  scsc_state_t     cur_st;
  logic [SN_W-1:0] cur_good;
  logic [SN_W-1:0] cur_rx;

  // Context written at the edge, so a back-to-back cell on the same VC sees it
  assign cur_st   = st_mem_q[CELL_VC_I];
  assign cur_good = good_mem_q[CELL_VC_I];
  assign cur_rx   = rx_mem_q[CELL_VC_I];

  logic            follows_rx;
  logic            follows_good;
  logic            good_plus2;
  logic [SN_W-1:0] gap;
  logic [SN_W-1:0] lost_cnt;

  assign follows_rx   = (rx_cnt == SN_W'(cur_rx + SN_ONE));
  assign follows_good = (rx_cnt == SN_W'(cur_good + SN_ONE));
  assign good_plus2   = (rx_cnt == SN_W'(cur_good + SN_TWO));
  // Cells missing between last good and the out-of-order cell
  assign gap          = SN_W'(cur_rx - cur_good - SN_ONE);
  assign lost_cnt     = (gap > MAX_LOST) ? MAX_LOST : gap;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and verdict

  logic            take;
  logic            wr_en;
  scsc_state_t     st_d;
  logic [SN_W-1:0] good_d;
  logic [SN_W-1:0] rx_d;
  logic            acc_d;
  logic            dis_d;
  logic            dum_d;
  logic [SN_W-1:0] dcnt_d;
  logic            sig_d;
  logic            seqe_d;
  logic            lost_d;
  logic            mis_d;

  assign take = run_q && CELL_VALID_I;

  always_comb begin
    wr_en  = 1'b0;
    st_d   = cur_st;
    good_d = cur_good;
    rx_d   = cur_rx;
    acc_d  = 1'b0;
    dis_d  = 1'b0;
    dum_d  = 1'b0;
    dcnt_d = SN_RST;
    sig_d  = 1'b0;
    seqe_d = 1'b0;
    lost_d = 1'b0;
    mis_d  = 1'b0;
    if (take) begin
      wr_en = 1'b1;
      if (sn_ok) begin
        rx_d = rx_cnt;
      end
      if (!sn_ok && cur_st != ST_SYNC) begin
        dis_d = 1'b1;
        st_d  = ST_START;
      end else begin
        unique case (cur_st)
          ST_START: begin
            dis_d = 1'b1;
            st_d  = ST_OUT_OF_SYNC;
          end
          ST_OUT_OF_SYNC: begin
            if (follows_rx) begin
              acc_d  = 1'b1;
              good_d = rx_cnt;
              st_d   = ST_SYNC;
            end else begin
              dis_d = 1'b1;
            end
          end
          ST_SYNC: begin
            acc_d = 1'b1;
            if (!sn_ok) begin
              st_d = ST_INVALID;
            end else if (follows_rx) begin
              sig_d  = 1'b1;
              good_d = rx_cnt;
            end else begin
              seqe_d = 1'b1;
              st_d   = ST_OUT_OF_SEQ;
            end
          end
          ST_INVALID: begin
            st_d = ST_SYNC;
            if (follows_good) begin
              dis_d  = 1'b1;
              mis_d  = 1'b1;
              good_d = rx_cnt;
            end else if (good_plus2) begin
              acc_d  = 1'b1;
              good_d = rx_cnt;
            end else begin
              dis_d = 1'b1;
              st_d  = ST_OUT_OF_SYNC;
            end
          end
          ST_OUT_OF_SEQ: begin
            st_d = ST_SYNC;
            if (follows_good) begin
              dis_d  = 1'b1;
              mis_d  = 1'b1;
              good_d = rx_cnt;
            end else if (follows_rx) begin
              // Dummies precede this cell, after the out-of-order one
              acc_d  = 1'b1;
              lost_d = 1'b1;
              dum_d  = (lost_cnt != SN_RST);
              dcnt_d = lost_cnt;
              good_d = rx_cnt;
            end else if (good_plus2) begin
              acc_d  = 1'b1;
              good_d = rx_cnt;
            end else begin
              dis_d = 1'b1;
              st_d  = ST_OUT_OF_SYNC;
            end
          end
        endcase
      end
    end
  end

  // Context store; reset puts every VC at start
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int v = 0; v < NUM_VC; v++) begin
        st_mem_q[v]   <= ST_START;
        good_mem_q[v] <= SN_RST;
        rx_mem_q[v]   <= SN_RST;
      end
    end else if (wr_en) begin
      st_mem_q[CELL_VC_I]   <= st_d;
      good_mem_q[CELL_VC_I] <= good_d;
      rx_mem_q[CELL_VC_I]   <= rx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      READY_O               <= 1'b0;
      VC_O                  <= '0;
      ACCEPT_O              <= 1'b0;
      DISCARD_O             <= 1'b0;
      DUMMY_O               <= 1'b0;
      DUMMY_CNT_O           <= SN_RST;
      SIG_UPD_O             <= 1'b0;
      SEQUENCE_ERROR_FLAG_O <= 1'b0;
      LOST_ERR_O            <= 1'b0;
      MISINS_ERR_O          <= 1'b0;
    end else begin
      READY_O               <= run_d;
      VC_O                  <= CELL_VC_I;
      ACCEPT_O              <= acc_d;
      DISCARD_O             <= dis_d;
      DUMMY_O               <= dum_d;
      DUMMY_CNT_O           <= dcnt_d;
      SIG_UPD_O             <= sig_d;
      SEQUENCE_ERROR_FLAG_O <= seqe_d;
      LOST_ERR_O            <= lost_d;
      MISINS_ERR_O          <= mis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  ready_after_rst_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    !run_q |=> run_q && READY_O)
    else $error("checker did not leave reset state");

  no_early_cell_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (CELL_VALID_I && !run_q) |=> !ACCEPT_O && !DISCARD_O)
    else $error("cell acted on before start");

  one_verdict_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    take |=> (ACCEPT_O != DISCARD_O) ##1 ($past(CELL_VALID_I) || (!ACCEPT_O && !DISCARD_O)))
    else $error("cell verdict not exactly one");

  bad_sn_restart_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (take && !sn_ok && cur_st != ST_SYNC) |=> DISCARD_O && !ACCEPT_O)
    else $error("invalid number not discarded");

  oos_resync_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (take && sn_ok && cur_st == ST_OUT_OF_SYNC && follows_rx) |=> ACCEPT_O && !SIG_UPD_O)
    else $error("resync cell not accepted");

  sig_upd_sync_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    SIG_UPD_O |-> ACCEPT_O && !SEQUENCE_ERROR_FLAG_O && $past(cur_st) == ST_SYNC
                  && $past(follows_rx) && $past(sn_ok))
    else $error("signalling update without in-sequence cell");

  seq_err_acc_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (take && sn_ok && cur_st == ST_SYNC && !follows_rx) |=> ACCEPT_O && SEQUENCE_ERROR_FLAG_O)
    else $error("sequence error not raised");

  misins_drop_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    MISINS_ERR_O |-> DISCARD_O && !ACCEPT_O && !DUMMY_O
                     && ($past(cur_st) == ST_INVALID || $past(cur_st) == ST_OUT_OF_SEQ))
    else $error("misinsertion handled wrongly");

  prot_fail_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (take && sn_ok && cur_st == ST_OUT_OF_SEQ && !follows_good && !follows_rx && good_plus2)
    |=> ACCEPT_O && !LOST_ERR_O)
    else $error("protection failure not accepted");

  loss_dummy_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    (take && sn_ok && cur_st == ST_OUT_OF_SEQ && !follows_good && follows_rx)
    |=> ACCEPT_O && LOST_ERR_O && DUMMY_CNT_O <= 3'h6)
    else $error("cell loss not handled");

  dummy_only_loss_a: assert property (
    @(posedge MCLK_I) disable iff (RST_I)
    DUMMY_O |-> LOST_ERR_O && ACCEPT_O && DUMMY_CNT_O != 3'h0)
    else $error("dummy cells outside a loss");

endmodule // scsc_checker
`default_nettype wire

/* verif/scsc_cell_src.sv */
// Behavioural cell receive path offering one sequence header per cell
`timescale 1ns/1ns
`default_nettype none
module scsc_cell_src
  import scsc_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Cell toward the checker
  output logic             cell_valid_o,
  output logic [VC_W-1:0]  cell_vc_o,
  output logic [HDR_W-1:0] cell_hdr_o
);
  initial begin
    cell_valid_o = 1'b0;
    cell_vc_o    = '0;
    cell_hdr_o   = '0;
  end

  ////////////////////////////////////////
  // CRC-3 over CSI and count, then even parity; bad spoils one CRC bit
  function automatic logic [HDR_W-1:0] hdr_of(input logic [SN_W-1:0] sn, input logic bad);
    logic [6:0]       r;
    logic [HDR_W-1:0] h;
    h      = '0;
    h[7:4] = {1'b0, sn};
    r      = {h[7:4], 3'h0};
    for (int i = 6; i >= 3; i--) begin
      if (r[i]) begin
        r[i-:4] = r[i-:4] ^ CRC_POLY;
      end
    end
    h[3:1] = r[2:0] ^ {2'h0, bad};
    h[0]   = ^h[7:1];
    return h;
  endfunction

  // Called at a rising edge; held through the taking edge
  task automatic offer(input logic [VC_W-1:0] vc, input logic [SN_W-1:0] sn, input logic bad);
    cell_valid_o <= 1'b1;
    cell_vc_o    <= vc;
    cell_hdr_o   <= hdr_of(sn, bad);
    @(posedge clk_i);
    // Inverted lines so no stale cell lingers
    cell_valid_o <= 1'b0;
    cell_vc_o    <= ~cell_vc_o;
    cell_hdr_o   <= ~cell_hdr_o;
  endtask
endmodule // scsc_cell_src
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the structured cell sequence checker
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import scsc_pkg::*;
;
  logic             MCLK_I;
  logic             RST_I;
  logic             CELL_VALID_I;
  logic [VC_W-1:0]  CELL_VC_I;
  logic [HDR_W-1:0] CELL_HDR_I;
  logic             READY_O, ACCEPT_O, DISCARD_O, DUMMY_O, SIG_UPD_O;
  logic             SEQUENCE_ERROR_FLAG_O, LOST_ERR_O, MISINS_ERR_O;
  logic [VC_W-1:0]  VC_O;
  logic [SN_W-1:0]  DUMMY_CNT_O;
  int               mismatches = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  wire [6:0] flg = {ACCEPT_O, DISCARD_O, DUMMY_O, SIG_UPD_O, SEQUENCE_ERROR_FLAG_O,
                    LOST_ERR_O, MISINS_ERR_O};
  localparam int A = 7'h40, D = 7'h20, DU = 7'h10, SG = 7'h08, SQ = 7'h04;
  localparam int LS = 7'h02, MI = 7'h01;

  scsc_cell_src src (.clk_i(MCLK_I), .cell_valid_o(CELL_VALID_I), .cell_vc_o(CELL_VC_I),
                     .cell_hdr_o(CELL_HDR_I));
  scsc_checker uut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CELL_VALID_I(CELL_VALID_I),
    .CELL_VC_I(CELL_VC_I), .CELL_HDR_I(CELL_HDR_I), .READY_O(READY_O), .VC_O(VC_O),
    .ACCEPT_O(ACCEPT_O), .DISCARD_O(DISCARD_O), .DUMMY_O(DUMMY_O), .DUMMY_CNT_O(DUMMY_CNT_O),
    .SIG_UPD_O(SIG_UPD_O), .SEQUENCE_ERROR_FLAG_O(SEQUENCE_ERROR_FLAG_O),
    .LOST_ERR_O(LOST_ERR_O), .MISINS_ERR_O(MISINS_ERR_O));

  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One cell, its one-cycle verdict, then quiet outputs
  task automatic c(input int v, input int sn, input int bad, input int ex, input int n = 0);
    @(posedge MCLK_I);
    src.offer(v[7:0], sn[2:0], bad[0]);
    #1;
    chk("ready", 8'h01, {7'h00, READY_O});
    chk("vc", v[7:0], VC_O);
    chk("flags", {1'b0, ex[6:0]}, {1'b0, flg});
    chk("dummies", {5'h00, n[2:0]}, {5'h00, DUMMY_CNT_O});
    @(posedge MCLK_I);
    #1;
    chk("idle", 8'h00, {1'b0, flg});
  endtask

  // Cell s-1 sits on the first edge after release and must be ignored
  task automatic sc_reset(input int v, input int s);
    RST_I <= 1'b1;
    repeat (7) @(posedge MCLK_I);
    #1;
    chk("rst ready", 8'h00, {7'h00, READY_O});
    chk("rst flags", 8'h00, {1'b0, flg});
    @(posedge MCLK_I);
    RST_I <= 1'b0;
    src.offer(v[7:0], 3'(s - 1), 1'b0);
    #1;
    chk("rel ready", 8'h01, {7'h00, READY_O});
    chk("ignored", 8'h00, {1'b0, flg});
    c(v, s, 0, D);
  endtask

  task automatic sc_sync();
    c(1, 0, 0, D);
    c(1, 2, 0, D);
    c(1, 3, 0, A);
    c(1, 4, 0, A | SG);
    c(1, 5, 1, A);
    c(1, 6, 0, A);
    c(1, 7, 0, A | SG);
    c(1, 1, 1, A);
    c(1, 0, 0, D | MI);
    c(1, 1, 1, A);
    c(1, 5, 0, D);
    c(1, 3, 1, D);
    c(1, 4, 0, D);
  endtask

  task automatic sc_loss();
    c(2, 1, 0, D);
    c(2, 2, 0, A);
    c(2, 6, 0, A | SQ);
    c(2, 7, 0, A | DU | LS, 3);
    c(2, 0, 0, A | SG);
    c(2, 7, 0, A | SQ);
    c(2, 0, 0, A | DU | LS, 6);
    c(2, 2, 0, A | SQ);
    c(2, 3, 0, A | DU | LS, 1);
  endtask

  task automatic sc_misord();
    c(3, 1, 0, D);
    c(3, 2, 0, A);
    c(3, 4, 0, A | SQ);
    c(3, 3, 0, D | MI);
    c(3, 5, 0, A | SQ);
    c(3, 6, 0, A | DU | LS, 1);
    c(3, 0, 0, A | SQ);
    c(3, 0, 0, A);
    c(3, 4, 0, A | SQ);
    c(3, 7, 0, D);
    c(3, 0, 0, A);
    // Bad numbers from sync, invalid, start and out_of_seq; the next good cell proves start
    c(3, 5, 1, A);
    c(3, 6, 1, D);
    c(3, 2, 1, D);
    c(3, 1, 0, D);
    c(3, 2, 0, A);
    c(3, 5, 0, A | SQ);
    c(3, 6, 1, D);
    c(3, 6, 0, D);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Some 47 cells at three cycles each sit far below this ceiling
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    RST_I = 1'b1;
    sc_reset(0, 2);
    sc_sync();
    sc_loss();
    sc_misord();
    c(9, 4, 0, D);
    c(9, 5, 0, A);
    sc_reset(9, 6);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
